// ### hw/cbbr_regs.sv
// Card bridge configuration registers and the socket controls they steer.
`timescale 1ns/1ns
// How it works
// - Interrupt pin reads fixed 01h, unwritable.
// - Control bits 15-11 and 4 read zero.
// - Bit 10 enables burst write posting.
// - Bit 9 window 1 prefetchable, resets 1.
// - Bit 8 window 0 prefetchable, resets 1.
// - Bit 7 routes card interrupts: PCI/legacy.
// - Bit 6 asserts card reset, resets 1.
// - Bus reset input also asserts card reset.
// - Bus reset leaves card reset bit alone only while events enabled.
// - Context bit (card reset only): bus reset restores reset value 1 unless events enabled.
// - Bit 5 reports card master abort.
// - Bit 3 forwards legacy video addresses.
// - Bit 2 filters upper 768 bytes per 1K.
// - Bit 1 forwards card system error.
// - Bit 0 reports card parity errors.
// - Vendor ident writable only while unlock bit 0.
// - Subsystem ident writable only while unlock bit 0.
// - Identity registers reset by global reset only.
// - Identity registers load from EEPROM after reset.
module cbbr_regs #(
  // Arbitrary reset values for the identity registers.
  parameter logic [15:0] SUBSYS_VENDOR_RESET = 16'h5a5a,
  parameter logic [15:0] SUBSYS_ID_RESET = 16'ha5a5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Device resets and power management
  input wire logic globalResetIn_n,
  input wire logic pciBusResetIn_n,
  input wire logic powerMgmtEventEnable,
  // Configuration access
  input wire cbbr_pkg::cbbr_cfg_req_type cfgReq,
  output logic cfgReadValid,
  output logic [31:0] cfgReadData,
  // System control mirror and EEPROM load
  input wire logic subsystemIdWriteUnlock,
  input wire logic eepromLoadValid,
  input wire logic [15:0] eepromSubsysVendor,
  input wire logic [15:0] eepromSubsysId,
  // Window and posting controls
  output logic writePostingEnable,
  output logic memWindow1Prefetchable,
  output logic memWindow0Prefetchable,
  // Card reset
  output logic cardResetOut_n,
  // Card interrupt routing
  input wire logic cardFuncIrq,
  output logic pciIntAReq,
  output logic legacyIrqReq,
  // Card error handling
  input wire logic cardMasterAbort,
  input wire logic sysErrEnable,
  input wire logic cardSysErr_n,
  input wire logic cardParityErrDetected,
  output logic pciTargetAbort,
  output logic pciSysErrReq,
  output logic cardParityErrOut_n,
  // Forwarding decision
  input wire cbbr_pkg::cbbr_fwd_req_type fwdReq,
  output logic fwdDecisionValid,
  output logic fwdToCard
);

  logic [15:0] bridgeCtrl_reg;
  logic [15:0] bridgeCtrl_next;
  logic cardResetBit_reg;
  logic cardResetBit_next;
  logic [15:0] subsysVendor_reg;
  logic [15:0] subsysVendor_next;
  logic [15:0] subsysId_reg;
  logic [15:0] subsysId_next;
  logic [15:0] bridgeCtrlView;
  logic globalReset;
  logic pciReset;
  logic [31:0] readWord;
  logic abortReported;
  logic cardSysErrForwarded;
  logic parityReported;
  logic irqToLegacy;

  // The read path packs two registers into each dword; refuse offsets that would break that pairing.
  if (cbbr_pkg::INT_PIN_OFFSET[7:2] != cbbr_pkg::BRIDGE_CTRL_OFFSET[7:2] ||
      cbbr_pkg::INT_PIN_OFFSET[1:0] != 2'h1 ||
      cbbr_pkg::BRIDGE_CTRL_OFFSET[1:0] != 2'h2) begin : g_bad_ctrl_pair
    $error("cbbr_regs: interrupt pin and bridge control must share one dword.");
  end
  if (cbbr_pkg::SUBSYS_VENDOR_OFFSET[7:2] != cbbr_pkg::SUBSYS_ID_OFFSET[7:2] ||
      cbbr_pkg::SUBSYS_VENDOR_OFFSET[1:0] != 2'h0 ||
      cbbr_pkg::SUBSYS_ID_OFFSET[1:0] != 2'h2) begin : g_bad_ident_pair
    $error("cbbr_regs: identity registers must share one dword.");
  end

  // A control field on a masked position would read back stuck at zero and never act.
  localparam int FIELD_COUNT = 10;
  localparam int FIELD_BITS [FIELD_COUNT] = '{cbbr_pkg::WRITE_POST_BIT, cbbr_pkg::WINDOW1_PREFETCH_BIT,
    cbbr_pkg::WINDOW0_PREFETCH_BIT, cbbr_pkg::IRQ_ROUTE_BIT, cbbr_pkg::CARD_RESET_BIT, cbbr_pkg::MASTER_ABORT_BIT,
    cbbr_pkg::VIDEO_FWD_BIT, cbbr_pkg::IO_FILTER_BIT, cbbr_pkg::SYSERR_FWD_BIT, cbbr_pkg::PARITY_REPORT_BIT};
  for (genvar i = 0; i < FIELD_COUNT; i++) begin : g_field_check
    if (!cbbr_pkg::BRIDGE_CTRL_WRITABLE[FIELD_BITS[i]]) begin : g_bad_field
      $error("cbbr_regs: a control field sits on a reserved bit.");
    end
  end

  // A byte lane of the request lands on the given byte offset.
  function automatic logic laneHit(input cbbr_pkg::cbbr_cfg_req_type req, input logic [7:0] offset);
    laneHit = req.write && (req.dwordAddr == offset[7:2]) && req.byteEn[offset[1:0]];
  endfunction : laneHit

  // The byte of the write data that goes to the given byte offset.
  function automatic logic [7:0] laneData(input cbbr_pkg::cbbr_cfg_req_type req, input logic [7:0] offset);
    laneData = req.writeData[8*offset[1:0] +: 8];
  endfunction : laneData

  assign globalReset = !rst_n || !globalResetIn_n;
  assign pciReset = !pciBusResetIn_n;

  // Bridge control without the card reset bit, which keeps its own reset scheme.
  always_comb begin
    bridgeCtrl_next = bridgeCtrl_reg;
    if (laneHit(cfgReq, cbbr_pkg::BRIDGE_CTRL_OFFSET)) begin
      bridgeCtrl_next[7:0] = laneData(cfgReq, cbbr_pkg::BRIDGE_CTRL_OFFSET);
    end
    if (laneHit(cfgReq, cbbr_pkg::BRIDGE_CTRL_OFFSET + 8'h01)) begin
      bridgeCtrl_next[15:8] = laneData(cfgReq, cbbr_pkg::BRIDGE_CTRL_OFFSET + 8'h01);
    end
    // Reserved positions stay zero whatever is written.
    bridgeCtrl_next = bridgeCtrl_next & cbbr_pkg::BRIDGE_CTRL_WRITABLE;
  end

  always_ff @(posedge clk) begin
    if (globalReset || pciReset) begin
      bridgeCtrl_reg <= cbbr_pkg::BRIDGE_CTRL_RESET & cbbr_pkg::BRIDGE_CTRL_WRITABLE;
    end else begin
      bridgeCtrl_reg <= bridgeCtrl_next;
    end
  end

  always_comb begin
    cardResetBit_next = cardResetBit_reg;
    if (laneHit(cfgReq, cbbr_pkg::BRIDGE_CTRL_OFFSET)) begin
      cardResetBit_next = cfgReq.writeData[8 * cbbr_pkg::BRIDGE_CTRL_OFFSET[1:0] + cbbr_pkg::CARD_RESET_BIT];
    end
  end

  // The card reset bit is power-management context: with events enabled only the
  // global reset returns it, so a bus reset cannot drop a card it is holding.
  always_ff @(posedge clk) begin
    if (globalReset || (pciReset && !powerMgmtEventEnable)) begin
      cardResetBit_reg <= cbbr_pkg::BRIDGE_CTRL_RESET[cbbr_pkg::CARD_RESET_BIT];
    end else begin
      cardResetBit_reg <= cardResetBit_next;
    end
  end

  // Identity registers: an EEPROM load outranks a host write in the same cycle.
  always_comb begin
    subsysVendor_next = subsysVendor_reg;
    subsysId_next = subsysId_reg;
    if (eepromLoadValid) begin
      subsysVendor_next = eepromSubsysVendor;
      subsysId_next = eepromSubsysId;
    end else if (!subsystemIdWriteUnlock) begin
      if (laneHit(cfgReq, cbbr_pkg::SUBSYS_VENDOR_OFFSET)) begin
        subsysVendor_next[7:0] = laneData(cfgReq, cbbr_pkg::SUBSYS_VENDOR_OFFSET);
      end
      if (laneHit(cfgReq, cbbr_pkg::SUBSYS_VENDOR_OFFSET + 8'h01)) begin
        subsysVendor_next[15:8] = laneData(cfgReq, cbbr_pkg::SUBSYS_VENDOR_OFFSET + 8'h01);
      end
      if (laneHit(cfgReq, cbbr_pkg::SUBSYS_ID_OFFSET)) begin
        subsysId_next[7:0] = laneData(cfgReq, cbbr_pkg::SUBSYS_ID_OFFSET);
      end
      if (laneHit(cfgReq, cbbr_pkg::SUBSYS_ID_OFFSET + 8'h01)) begin
        subsysId_next[15:8] = laneData(cfgReq, cbbr_pkg::SUBSYS_ID_OFFSET + 8'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (globalReset) begin
      subsysVendor_reg <= SUBSYS_VENDOR_RESET;
      subsysId_reg <= SUBSYS_ID_RESET;
    end else begin
      subsysVendor_reg <= subsysVendor_next;
      subsysId_reg <= subsysId_next;
    end
  end

  // Read path.
  always_comb begin
    bridgeCtrlView = bridgeCtrl_reg;
    bridgeCtrlView[cbbr_pkg::CARD_RESET_BIT] = cardResetBit_reg;
    readWord = 32'h0000_0000;
    if (cfgReq.dwordAddr == cbbr_pkg::INT_PIN_OFFSET[7:2]) begin
      readWord[8*cbbr_pkg::INT_PIN_OFFSET[1:0] +: 8] = cbbr_pkg::INT_PIN_VALUE;
      readWord[8*cbbr_pkg::BRIDGE_CTRL_OFFSET[1:0] +: 16] = bridgeCtrlView;
    end else if (cfgReq.dwordAddr == cbbr_pkg::SUBSYS_VENDOR_OFFSET[7:2]) begin
      readWord[8*cbbr_pkg::SUBSYS_VENDOR_OFFSET[1:0] +: 16] = subsysVendor_reg;
      readWord[8*cbbr_pkg::SUBSYS_ID_OFFSET[1:0] +: 16] = subsysId_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgReadValid <= 1'b0;
      cfgReadData <= 32'h0000_0000;
    end else begin
      cfgReadValid <= cfgReq.read;
      if (cfgReq.read) begin
        cfgReadData <= readWord;
      end
    end
  end

  // Write posting toward the socket datapath.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      writePostingEnable <= cbbr_pkg::BRIDGE_CTRL_RESET[cbbr_pkg::WRITE_POST_BIT];
    end else begin
      writePostingEnable <= bridgeCtrl_reg[cbbr_pkg::WRITE_POST_BIT];
    end
  end

  // Window types; both windows start prefetchable.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memWindow1Prefetchable <= cbbr_pkg::BRIDGE_CTRL_RESET[cbbr_pkg::WINDOW1_PREFETCH_BIT];
      memWindow0Prefetchable <= cbbr_pkg::BRIDGE_CTRL_RESET[cbbr_pkg::WINDOW0_PREFETCH_BIT];
    end else begin
      memWindow1Prefetchable <= bridgeCtrl_reg[cbbr_pkg::WINDOW1_PREFETCH_BIT];
      memWindow0Prefetchable <= bridgeCtrl_reg[cbbr_pkg::WINDOW0_PREFETCH_BIT];
    end
  end

  // Card reset follows one cycle behind its causes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cardResetOut_n <= 1'b0;
    end else begin
      cardResetOut_n <= !(cardResetBit_reg || pciReset);
    end
  end

  // Card functional interrupt goes to exactly one destination.
  assign irqToLegacy = bridgeCtrl_reg[cbbr_pkg::IRQ_ROUTE_BIT];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pciIntAReq <= 1'b0;
      legacyIrqReq <= 1'b0;
    end else begin
      pciIntAReq <= cardFuncIrq && !irqToLegacy;
      legacyIrqReq <= cardFuncIrq && irqToLegacy;
    end
  end

  // Decoded error terms; the abort report feeds both target abort and system error.
  assign abortReported = cardMasterAbort && bridgeCtrl_reg[cbbr_pkg::MASTER_ABORT_BIT];
  assign cardSysErrForwarded = !cardSysErr_n && bridgeCtrl_reg[cbbr_pkg::SYSERR_FWD_BIT];
  assign parityReported = cardParityErrDetected && bridgeCtrl_reg[cbbr_pkg::PARITY_REPORT_BIT];

  // Target abort toward the host.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pciTargetAbort <= 1'b0;
    end else begin
      pciTargetAbort <= abortReported;
    end
  end

  // System error merges abort reports with forwarded card errors.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pciSysErrReq <= 1'b0;
    end else begin
      pciSysErrReq <= (abortReported && sysErrEnable) || cardSysErrForwarded;
    end
  end

  // Parity report toward the card side.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cardParityErrOut_n <= 1'b1;
    end else begin
      cardParityErrOut_n <= !parityReported;
    end
  end

  cbbr_fwd_decode #(
    .RANGE_BITS(cbbr_pkg::ISA_RANGE_BITS)
  ) u_fwd_decode (
    .clk(clk),
    .rst_n(rst_n),
    .videoForwardEnable(bridgeCtrl_reg[cbbr_pkg::VIDEO_FWD_BIT]),
    .ioFilterEnable(bridgeCtrl_reg[cbbr_pkg::IO_FILTER_BIT]),
    .fwdReq(fwdReq),
    .fwdDecisionValid(fwdDecisionValid),
    .fwdToCard(fwdToCard)
  );

endmodule : cbbr_regs

// ### hw/cbbr_pkg.sv
// Shared constants and carrier types for the card bridge control registers.
package cbbr_pkg;

  // Byte offsets in configuration space.
  localparam logic [7:0] INT_PIN_OFFSET = 8'h3d;
  localparam logic [7:0] BRIDGE_CTRL_OFFSET = 8'h3e;
  localparam logic [7:0] SUBSYS_VENDOR_OFFSET = 8'h40;
  localparam logic [7:0] SUBSYS_ID_OFFSET = 8'h42;

  // Fixed and reset values.
  localparam logic [7:0] INT_PIN_VALUE = 8'h01;
  localparam logic [15:0] BRIDGE_CTRL_RESET = 16'h0340;
  localparam logic [15:0] BRIDGE_CTRL_WRITABLE = 16'h07ef;

  // Bridge control field positions.
  localparam int WRITE_POST_BIT = 10;
  localparam int WINDOW1_PREFETCH_BIT = 9;
  localparam int WINDOW0_PREFETCH_BIT = 8;
  localparam int IRQ_ROUTE_BIT = 7;
  localparam int CARD_RESET_BIT = 6;
  localparam int MASTER_ABORT_BIT = 5;
  localparam int VIDEO_FWD_BIT = 3;
  localparam int IO_FILTER_BIT = 2;
  localparam int SYSERR_FWD_BIT = 1;
  localparam int PARITY_REPORT_BIT = 0;

  // Legacy video windows.
  localparam logic [31:0] VIDEO_MEM_LOW = 32'h000a_0000;
  localparam logic [31:0] VIDEO_MEM_HIGH = 32'h000b_ffff;
  localparam logic [31:0] VIDEO_IO_A_LOW = 32'h0000_03b0;
  localparam logic [31:0] VIDEO_IO_A_HIGH = 32'h0000_03bb;
  localparam logic [31:0] VIDEO_IO_B_LOW = 32'h0000_03c0;
  localparam logic [31:0] VIDEO_IO_B_HIGH = 32'h0000_03df;

  // Legacy I/O filter: in each 1K block of the first 64K only the lowest 256 bytes pass.
  localparam int ISA_RANGE_BITS = 16;

  // One configuration access from the host.
  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] dwordAddr;
    logic [3:0] byteEn;
    logic [31:0] writeData;
  } cbbr_cfg_req_type;

  // One transaction offered for forwarding to the card.
  typedef struct packed {
    logic valid;
    logic isIo;
    logic inWindow;
    logic [31:0] addr;
  } cbbr_fwd_req_type;

endpackage : cbbr_pkg

// ### hw/cbbr_fwd_decode.sv
// Forwarding decision for legacy video and legacy I/O filtering.
`timescale 1ns/1ns
module cbbr_fwd_decode #(
  parameter int RANGE_BITS = cbbr_pkg::ISA_RANGE_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic videoForwardEnable,
  input wire logic ioFilterEnable,
  // Request
  input wire cbbr_pkg::cbbr_fwd_req_type fwdReq,
  // Decision
  output logic fwdDecisionValid,
  output logic fwdToCard
);

  if (RANGE_BITS < 10 || RANGE_BITS > 31) begin : g_bad_range
    $error("cbbr_fwd_decode: RANGE_BITS must be 10 to 31.");
  end

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  logic videoHit;
  logic isaBlocked;
  logic decision;

  always_comb begin
    videoHit = fwdReq.isIo ?
      (inRange(fwdReq.addr, cbbr_pkg::VIDEO_IO_A_LOW, cbbr_pkg::VIDEO_IO_A_HIGH) ||
       inRange(fwdReq.addr, cbbr_pkg::VIDEO_IO_B_LOW, cbbr_pkg::VIDEO_IO_B_HIGH)) :
      inRange(fwdReq.addr, cbbr_pkg::VIDEO_MEM_LOW, cbbr_pkg::VIDEO_MEM_HIGH);
    // Upper 768 bytes of every 1K block below the range limit are held back.
    isaBlocked = ioFilterEnable && fwdReq.isIo && (fwdReq.addr[31:RANGE_BITS] == '0) &&
                 (fwdReq.addr[9:8] != 2'h0);
    decision = (fwdReq.inWindow && !isaBlocked) || (videoForwardEnable && videoHit);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwdDecisionValid <= 1'b0;
      fwdToCard <= 1'b0;
    end else begin
      fwdDecisionValid <= fwdReq.valid;
      fwdToCard <= fwdReq.valid && decision;
    end
  end

endmodule : cbbr_fwd_decode

// ### verification/cbbr_regs_checker.sv
// Concurrent checks on the card bridge register block ports.
`timescale 1ns/1ns
module cbbr_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic pciBusResetIn_n,
  input wire cbbr_pkg::cbbr_cfg_req_type cfgReq,
  input wire logic cfgReadValid,
  input wire logic cardResetOut_n,
  input wire logic cardFuncIrq,
  input wire logic pciIntAReq,
  input wire logic legacyIrqReq,
  input wire logic cardMasterAbort,
  input wire logic pciTargetAbort,
  input wire logic cardParityErrDetected,
  input wire logic cardParityErrOut_n,
  input wire cbbr_pkg::cbbr_fwd_req_type fwdReq,
  input wire logic fwdDecisionValid,
  input wire logic fwdToCard
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (cfgReq.read |=> cfgReadValid)
    else $error("Read not answered.");
  read_cause_a: assert property (cfgReadValid |-> $past(cfgReq.read))
    else $error("Read answer without a read.");
  card_reset_a: assert property (!pciBusResetIn_n |=> !cardResetOut_n)
    else $error("Bus reset not passed to card.");
  irq_route_a: assert property (cardFuncIrq |=> pciIntAReq != legacyIrqReq)
    else $error("Card interrupt not routed once.");
  abort_gate_a: assert property (pciTargetAbort |-> $past(cardMasterAbort))
    else $error("Target abort without cause.");
  parity_gate_a: assert property (!cardParityErrOut_n |-> $past(cardParityErrDetected))
    else $error("Parity report without cause.");
  fwd_answer_a: assert property (fwdReq.valid |=> fwdDecisionValid)
    else $error("Forward decision missing.");
  fwd_quiet_a: assert property (!fwdDecisionValid |-> !fwdToCard)
    else $error("Forward flag outside decision.");
  cover property (legacyIrqReq);
  cover property (pciTargetAbort);
  cover property (fwdDecisionValid && !fwdToCard);
endmodule : cbbr_regs_checker

// ### verification/cbbr_card_model.sv
// Card-side partner that raises interrupt, error and abort lines.
`timescale 1ns/1ns
module cbbr_card_model (
  // Clock and card reset
  input wire logic clk,
  input wire logic cardResetOut_n,
  // Card signals
  output logic cardFuncIrq,
  output logic cardSysErr_n,
  output logic cardParityErrDetected,
  output logic cardMasterAbort
);
  initial begin
    cardFuncIrq = 1'b0;
    cardSysErr_n = 1'b1;
    cardParityErrDetected = 1'b0;
    cardMasterAbort = 1'b0;
  end
  // A card held in reset cannot signal, so requests made then are dropped.
  task automatic drive(input logic irq, input logic serr, input logic perr, input logic abort);
    cardFuncIrq = irq & cardResetOut_n;
    cardSysErr_n = !(serr & cardResetOut_n);
    cardParityErrDetected = perr & cardResetOut_n;
    cardMasterAbort = abort & cardResetOut_n;
    if (abort) begin
      @(posedge clk);
      #1;
      cardMasterAbort = 1'b0;
    end
  endtask : drive
endmodule : cbbr_card_model

// ### verification/test_cbbr_regs.sv
// Self-checking bench for the card bridge configuration registers.
`timescale 1ns/1ns
module test_cbbr_regs;
  logic clk, rst_n, globalResetIn_n, pciBusResetIn_n, powerMgmtEventEnable, cfgReadValid;
  logic subsystemIdWriteUnlock, eepromLoadValid, writePostingEnable, memWindow1Prefetchable;
  logic memWindow0Prefetchable, cardResetOut_n, cardFuncIrq, pciIntAReq, legacyIrqReq, cardMasterAbort;
  logic sysErrEnable, cardSysErr_n, cardParityErrDetected, pciTargetAbort, pciSysErrReq;
  logic cardParityErrOut_n, fwdDecisionValid, fwdToCard;
  logic [15:0] eepromSubsysVendor, eepromSubsysId;
  logic [31:0] cfgReadData;
  cbbr_pkg::cbbr_cfg_req_type cfgReq;
  cbbr_pkg::cbbr_fwd_req_type fwdReq;
  int failures, totalChecks, cycles;
  cbbr_regs dut_u (.clk, .rst_n, .globalResetIn_n, .pciBusResetIn_n, .powerMgmtEventEnable, .cfgReq,
    .cfgReadValid, .cfgReadData, .subsystemIdWriteUnlock, .eepromLoadValid, .eepromSubsysVendor,
    .eepromSubsysId, .writePostingEnable, .memWindow1Prefetchable, .memWindow0Prefetchable, .cardResetOut_n,
    .cardFuncIrq, .pciIntAReq, .legacyIrqReq, .cardMasterAbort, .sysErrEnable, .cardSysErr_n,
    .cardParityErrDetected, .pciTargetAbort, .pciSysErrReq, .cardParityErrOut_n, .fwdReq,
    .fwdDecisionValid, .fwdToCard);
  cbbr_card_model card_u (.clk, .cardResetOut_n, .cardFuncIrq, .cardSysErr_n, .cardParityErrDetected,
    .cardMasterAbort);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // The bus is idled for a cycle after each access so no write lingers.
  task automatic access(input logic w, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    cfgReq = '{w, !w, a, be, d};
    step();
    if (!w) check(cfgReadValid, 1'b1);
    cfgReq = '0;
    step();
  endtask : access
  task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    access(1'b1, a, be, d);
  endtask : wr
  task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 4'hf, 32'h0);
    q = cfgReadData;
    check(q, exp);
  endtask : rdChk
  task automatic controlWord;
    rdChk(6'h0f, 32'h0340_0100);
    check({writePostingEnable, memWindow1Prefetchable, memWindow0Prefetchable, cardResetOut_n}, 4'h6);
    wr(6'h0f, 4'hf, 32'hffff_ffff);
    rdChk(6'h0f, 32'h07ef_0100);
    check({writePostingEnable, memWindow1Prefetchable, memWindow0Prefetchable, cardResetOut_n}, 4'he);
    wr(6'h0f, 4'h4, 32'h0);
    rdChk(6'h0f, 32'h0700_0100);
    wr(6'h0f, 4'h8, 32'h0);
    check({writePostingEnable, memWindow1Prefetchable, memWindow0Prefetchable, cardResetOut_n}, 4'h1);
    wr(6'h03, 4'hf, 32'hffff_ffff);
    rdChk(6'h03, 32'h0);
  endtask : controlWord
  task automatic busReset(input logic pm, input logic [31:0] exp);
    wr(6'h10, 4'hf, 32'h1234_5678);
    wr(6'h0f, 4'hc, 32'h0427_0000);
    powerMgmtEventEnable = pm;
    pciBusResetIn_n = 1'b0;
    step(2);
    check(cardResetOut_n, 1'b0);
    pciBusResetIn_n = 1'b1;
    step(2);
    rdChk(6'h0f, exp);
    rdChk(6'h10, 32'h1234_5678);
  endtask : busReset
  task automatic identity;
    globalResetIn_n = 1'b0;
    step();
    globalResetIn_n = 1'b1;
    step();
    rdChk(6'h10, 32'ha5a5_5a5a);
    subsystemIdWriteUnlock = 1'b1;
    wr(6'h10, 4'hf, 32'h1111_2222);
    rdChk(6'h10, 32'ha5a5_5a5a);
    eepromSubsysVendor = 16'hbeef;
    eepromSubsysId = 16'hcafe;
    eepromLoadValid = 1'b1;
    step();
    eepromLoadValid = 1'b0;
    rdChk(6'h10, 32'hcafe_beef);
    subsystemIdWriteUnlock = 1'b0;
    wr(6'h10, 4'hc, 32'h4321_0000);
    rdChk(6'h10, 32'h4321_beef);
  endtask : identity
  task automatic sideSignals;
    wr(6'h0f, 4'hc, 32'h00a3_0000);
    sysErrEnable = 1'b1;
    card_u.drive(1'b1, 1'b1, 1'b1, 1'b0);
    step();
    check({pciIntAReq, legacyIrqReq, cardParityErrOut_n, pciSysErrReq}, 4'h5);
    card_u.drive(1'b0, 1'b0, 1'b0, 1'b1);
    check({pciTargetAbort, pciSysErrReq, pciIntAReq, legacyIrqReq}, 4'hc);
    step();
    sysErrEnable = 1'b0;
    card_u.drive(1'b0, 1'b0, 1'b0, 1'b1);
    check({pciTargetAbort, pciSysErrReq}, 2'h2);
    wr(6'h0f, 4'hc, 32'h0);
    card_u.drive(1'b1, 1'b1, 1'b1, 1'b1);
    check({pciTargetAbort, pciSysErrReq, pciIntAReq, cardParityErrOut_n}, 4'h3);
    step();
    card_u.drive(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : sideSignals
  task automatic forward;
    wr(6'h0f, 4'hc, 32'h000c_0000);
    fwdReq = '{1'b1, 1'b1, 1'b1, 32'h0000_0100};
    step();
    check({fwdDecisionValid, fwdToCard}, 2'h2);
    fwdReq = '{1'b1, 1'b0, 1'b0, 32'h000a_0000};
    step();
    check({fwdDecisionValid, fwdToCard}, 2'h3);
    fwdReq = '{1'b1, 1'b1, 1'b1, 32'h0000_0000};
    step();
    check({fwdDecisionValid, fwdToCard}, 2'h3);
    fwdReq = '0;
    step();
    check({fwdDecisionValid, fwdToCard}, 2'h0);
  endtask : forward
  task automatic give_verdict;
    if (failures == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("Error %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    globalResetIn_n = 1'b1;
    pciBusResetIn_n = 1'b1;
    powerMgmtEventEnable = 1'b0;
    subsystemIdWriteUnlock = 1'b0;
    eepromLoadValid = 1'b0;
    eepromSubsysVendor = 16'h0;
    eepromSubsysId = 16'h0;
    sysErrEnable = 1'b0;
    cfgReq = '0;
    fwdReq = '0;
    step(10);
    rst_n = 1'b1;
    controlWord();
    busReset(1'b1, 32'h0300_0100);
    busReset(1'b0, 32'h0340_0100);
    identity();
    sideSignals();
    forward();
    give_verdict();
  end
endmodule : test_cbbr_regs
bind cbbr_regs cbbr_regs_checker chk_u (.clk, .rst_n, .pciBusResetIn_n, .cfgReq, .cfgReadValid, .cardResetOut_n,
  .cardFuncIrq, .pciIntAReq, .legacyIrqReq, .cardMasterAbort, .pciTargetAbort, .cardParityErrDetected,
  .cardParityErrOut_n, .fwdReq, .fwdDecisionValid, .fwdToCard);
